// ### src/hqc_pkg.sv
// Constants for the per-queue manager: offsets, fields, sizes, timing.
// Assumes an 8-bit host register port on a single 50 MHz clock.
package hqc_pkg;
	// Register offsets
	localparam logic [7:0] OFF_WP_LO    = 8'h04;
	localparam logic [7:0] OFF_WP_HI    = 8'h05;
	localparam logic [7:0] OFF_RP_LO    = 8'h06;
	localparam logic [7:0] OFF_RP_HI    = 8'h07;
	localparam logic [7:0] OFF_FIN      = 8'h0c;
	localparam logic [7:0] OFF_FOUT     = 8'h0d;
	localparam logic [7:0] OFF_INC_RES  = 8'h0e;
	localparam logic [7:0] OFF_QSEL     = 8'h0f;
	localparam logic [7:0] OFF_DATA     = 8'h80;
	localparam logic [7:0] OFF_DATA_H   = 8'h84;
	localparam logic [7:0] OFF_INT_DATA = 8'h88;
	localparam logic [7:0] OFF_CONN     = 8'hfa;
	localparam logic [7:0] OFF_SUBCH    = 8'hfb;
	localparam logic [7:0] OFF_CHAN     = 8'hfc;
	localparam logic [7:0] OFF_SEQ      = 8'hfd;
	// Own control and status registers
	localparam logic [7:0] OFF_CTRL     = 8'h01;
	localparam logic [7:0] OFF_LAYOUT   = 8'h0b;
	localparam logic [7:0] OFF_STATUS   = 8'h1c;
	// Field positions
	localparam int BIT_DIR   = 0;
	localparam int BIT_NUM_L = 1;
	localparam int BIT_LOOP  = 6;
	localparam int BIT_INV   = 7;
	localparam int BIT_TERM  = 6;
	localparam int BIT_REV   = 7;
	localparam int BIT_BYP   = 1;
	localparam int BIT_IRQ_L = 2;
	localparam int BIT_INCF  = 0;
	localparam int BIT_RESF  = 1;
	localparam int BIT_SRES  = 3;
	localparam int BIT_FRES  = 6;
	localparam int BIT_FSM   = 3;
	// Sizes
	localparam int NQ        = 64;
	localparam int QW        = 6;
	localparam int PW        = 16;
	localparam logic [1:0] RAM_32K = 2'h0;
	localparam logic [4:0] FMAX_SMALL = 5'h0f;
	localparam logic [4:0] FMAX_LARGE = 5'h1f;
	localparam logic [2:0] CNT_ALL = 3'h0;
	localparam logic [2:0] CNT_SIX = 3'h6;
	// Default layout limits per memory size
	localparam logic [15:0] ZMIN_32K  = 16'h0080;
	localparam logic [15:0] ZMAX_32K  = 16'h01ff;
	localparam logic [15:0] ZMIN_EXT  = 16'h00c0;
	localparam logic [15:0] ZMAX_128K = 16'h07ff;
	localparam logic [15:0] ZMAX_512K = 16'h1fff;
	localparam logic [15:0] ZMIN_BIG  = 16'h0000;
	// Busy time
	localparam int CLK_MHZ  = 50;
	localparam int BUSY_CYC = 25;
	localparam logic [4:0] BUSY_CNT = 5'(BUSY_CYC - 1);
endpackage

// ### src/hqc_queue.sv
// Per-queue counters, configuration and two-entry output buffer.
// Assumes host port and line side share clk; frame sync is an async pin.
`timescale 1ns/1ns
`default_nettype none
module hqc_queue (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       clk_en,
	// Host byte register port
	input  wire logic       host_wr,
	input  wire logic       host_rd,
	input  wire logic [7:0] host_addr,
	input  wire logic [7:0] host_wdata,
	output var  logic [7:0] host_rdata_reg,
	output var  logic       busy_reg,
	// Line side
	input  wire logic       frame_sync_pulse,
	input  wire logic [7:0] line_rx_byte,
	output var  logic [7:0] line_tx_byte_reg,
	output var  logic       line_tx_valid_reg,
	input  wire logic       line_tx_ready
);
	typedef enum logic [1:0] {HQC_IDLE, HQC_SCAN, HQC_DONE} hqc_state_t;

	// Per-queue storage and the shared data memory
	logic [15:0] wp      [hqc_pkg::NQ];
	logic [15:0] rp      [hqc_pkg::NQ];
	logic [4:0]  fin     [hqc_pkg::NQ];
	logic [4:0]  fout    [hqc_pkg::NQ];
	logic [7:0]  subch   [hqc_pkg::NQ];
	logic [7:0]  conn    [hqc_pkg::NQ];
	logic [7:0]  chan    [hqc_pkg::NQ];
	logic [7:0]  seq     [hqc_pkg::NQ];
	logic [7:0]  mem     [1 << hqc_pkg::PW];

	logic [7:0]  qsel_reg;
	logic [7:0]  layout_reg;
	logic [1:0]  ram_sz_reg;
	logic [4:0]  busy_cnt_reg;
	logic [1:0]  sync_ff_reg;
	logic        sync_old_reg;
	logic [5:0]  scan_reg;
	logic [7:0]  last_tx_reg;
	hqc_state_t  state_reg;
	// Two-entry buffer
	logic [7:0]  buf_data_reg [2];
	logic [1:0]  buf_cnt_reg;
	logic        buf_rd_reg;
	logic        buf_wr_reg;

	logic [5:0]  q;
	logic [15:0] zmin;
	logic [15:0] zmax;
	logic [4:0]  fmax;
	logic        cfg_wr;
	logic        soft_rst;
	logic        sync_edge;
	logic        scan_en;
	logic        scan_tx;
	logic [15:0] wp_next;
	logic [15:0] rp_next;
	logic [7:0]  sel_mask;
	logic [7:0]  tx_byte_next;
	logic        buf_push;
	logic        buf_pop;
	logic [2:0]  nbits;
	logic [7:0]  ones;
	logic [15:0] rp_host_next;
	logic [7:0]  rd_byte;
	logic [7:0]  wdata_rev;
	logic [7:0]  rdata_rev;

	assign q = {qsel_reg[hqc_pkg::QW - 1:hqc_pkg::BIT_NUM_L],
		qsel_reg[hqc_pkg::BIT_DIR]};
	assign fmax = (ram_sz_reg == hqc_pkg::RAM_32K) ? hqc_pkg::FMAX_SMALL :
		hqc_pkg::FMAX_LARGE;

	// Queue limits from memory size and layout
	always_comb begin
		if (layout_reg[1:0] == 2'h3) begin
			zmin = hqc_pkg::ZMIN_BIG;
		end else if (ram_sz_reg == hqc_pkg::RAM_32K) begin
			zmin = hqc_pkg::ZMIN_32K;
		end else begin
			zmin = hqc_pkg::ZMIN_EXT;
		end
		unique case (ram_sz_reg)
			2'h1:    zmax = hqc_pkg::ZMAX_128K;
			2'h2:    zmax = hqc_pkg::ZMAX_512K;
			default: zmax = hqc_pkg::ZMAX_32K;
		endcase
	end

	assign cfg_wr   = clk_en && host_wr && busy_cnt_reg == 5'h00;
	assign soft_rst = clk_en && host_wr && host_addr == hqc_pkg::OFF_CTRL &&
		(host_wdata[hqc_pkg::BIT_SRES] || host_wdata[hqc_pkg::BIT_FRES]);
	assign wp_next = (wp[q] == zmax) ? zmin : wp[q] + 16'h0001;
	assign rp_next = (rp[scan_reg] == zmax) ? zmin :
		rp[scan_reg] + 16'h0001;
	// Host data port reads the byte after the read pointer
	assign rp_host_next = (rp[q] == zmax) ? zmin :
		rp[q] + 16'h0001;
	assign rd_byte = mem[rp_host_next];
	assign sync_edge = sync_ff_reg[1] && !sync_old_reg;
	assign scan_tx = !scan_reg[0];
	assign scan_en = (conn[scan_reg][hqc_pkg::BIT_BYP] ||
		conn[scan_reg][4:2] != 3'h0);

	// Bit selection mask from count and start bit
	always_comb begin
		nbits = subch[scan_reg][2:0];
		if (nbits == hqc_pkg::CNT_ALL) begin
			ones = 8'hff;
		end else begin
			ones = 8'((9'h001 << nbits) - 9'h001);
		end
		sel_mask = 8'(ones << subch[scan_reg][5:3]);
		// Next byte sits after the read pointer
		tx_byte_next = mem[rp_next] & sel_mask;
		if (subch[scan_reg][hqc_pkg::BIT_INV]) begin
			tx_byte_next = ~tx_byte_next;
		end
	end

	// Bit order reversal for host data
	always_comb begin
		for (int b = 0; b < 8; b++) begin
			wdata_rev[b] = host_wdata[7 - b];
			rdata_rev[b] = rd_byte[7 - b];
		end
	end

	// Frame sync pin synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_ff_reg  <= 2'h0;
			sync_old_reg <= 1'b0;
		end else if (clk_en) begin
			sync_ff_reg  <= {sync_ff_reg[0], frame_sync_pulse};
			sync_old_reg <= sync_ff_reg[1];
		end
	end

	// Control registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			qsel_reg   <= 8'h00;
			layout_reg <= 8'h00;
			ram_sz_reg <= 2'h0;
		end else if (clk_en && host_wr) begin
			if (cfg_wr && host_addr == hqc_pkg::OFF_QSEL &&
				!layout_reg[hqc_pkg::BIT_FSM]) begin
				qsel_reg <= host_wdata;
			end
			if (cfg_wr && host_addr == hqc_pkg::OFF_LAYOUT) begin
				layout_reg <= host_wdata;
			end
			// Control register stays writable while busy
			if (host_addr == hqc_pkg::OFF_CTRL) begin
				ram_sz_reg <= host_wdata[1:0];
			end
		end
	end

	// Busy timer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_cnt_reg <= 5'h00;
			busy_reg     <= 1'b0;
		end else if (clk_en) begin
			if (cfg_wr && (host_addr == hqc_pkg::OFF_QSEL ||
				host_addr == hqc_pkg::OFF_INC_RES)) begin
				busy_cnt_reg <= hqc_pkg::BUSY_CNT;
				busy_reg     <= 1'b1;
			end else if (busy_cnt_reg != 5'h00) begin
				busy_cnt_reg <= busy_cnt_reg - 5'h01;
				busy_reg     <= busy_cnt_reg != 5'h01;
			end else begin
				busy_reg <= 1'b0;
			end
		end
	end

	// Per-queue configuration arrays
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < hqc_pkg::NQ; i++) begin
				subch[i] <= 8'h00;
				conn[i]  <= 8'h00;
				chan[i]  <= 8'h00;
				seq[i]   <= 8'h00;
			end
		end else if (soft_rst) begin
			for (int i = 0; i < hqc_pkg::NQ; i++) begin
				conn[i] <= 8'h00;
			end
		end else if (cfg_wr) begin
			unique case (host_addr)
				hqc_pkg::OFF_SUBCH: subch[q] <= host_wdata;
				hqc_pkg::OFF_CONN:  conn[q]  <= host_wdata;
				hqc_pkg::OFF_CHAN:  chan[q]  <= {2'h0, host_wdata[5:0]};
				hqc_pkg::OFF_SEQ:   seq[q]   <= {1'b0, host_wdata[6:0]};
				default: ;
			endcase
		end
	end

	// Pointers, frame counters and memory
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < hqc_pkg::NQ; i++) begin
				wp[i]   <= hqc_pkg::ZMAX_32K;
				rp[i]   <= hqc_pkg::ZMAX_32K;
				fin[i]  <= hqc_pkg::FMAX_SMALL;
				fout[i] <= hqc_pkg::FMAX_SMALL;
			end
		end else if (soft_rst) begin
			for (int i = 0; i < hqc_pkg::NQ; i++) begin
				wp[i]   <= zmax;
				rp[i]   <= zmax;
				fin[i]  <= fmax;
				fout[i] <= fmax;
			end
		end else if (clk_en) begin
			if (cfg_wr && host_addr == hqc_pkg::OFF_INC_RES) begin
				if (host_wdata[hqc_pkg::BIT_RESF]) begin
					wp[q]   <= zmax;
					rp[q]   <= zmax;
					fin[q]  <= fmax;
					fout[q] <= fmax;
				end else if (host_wdata[hqc_pkg::BIT_INCF]) begin
					if (!q[0]) begin
						fin[q] <= (fin[q] == fmax) ? 5'h00 :
							fin[q] + 5'h01;
					end else begin
						fout[q] <= (fout[q] == fmax) ? 5'h00 :
							fout[q] + 5'h01;
					end
				end
			end else if (cfg_wr && host_addr == hqc_pkg::OFF_DATA &&
				!q[0]) begin
				mem[wp_next] <= qsel_reg[hqc_pkg::BIT_REV] ? wdata_rev :
					host_wdata;
				wp[q] <= wp_next;
			end
			if (state_reg == HQC_SCAN && scan_en) begin
				if (scan_tx && buf_push && !(subch[scan_reg][hqc_pkg::BIT_LOOP]
					&& conn[scan_reg][hqc_pkg::BIT_BYP])) begin
					rp[scan_reg] <= rp_next;
				end else if (!scan_tx) begin
					mem[(wp[scan_reg] == zmax) ? zmin :
						wp[scan_reg] + 16'h0001] <= line_rx_byte;
					wp[scan_reg] <= (wp[scan_reg] == zmax) ? zmin :
						wp[scan_reg] + 16'h0001;
				end
			end
		end
	end

	// Frame sync scan over all queues
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= HQC_IDLE;
			scan_reg  <= 6'h00;
		end else if (clk_en) begin
			unique case (state_reg)
				HQC_IDLE: begin
					scan_reg <= 6'h00;
					if (sync_edge) begin
						state_reg <= HQC_SCAN;
					end
				end
				HQC_SCAN: begin
					if (!scan_tx || buf_push || !scan_en ||
						wp[scan_reg] == rp[scan_reg]) begin
						scan_reg <= scan_reg + 6'h01;
						if (scan_reg == 6'h3f) begin
							state_reg <= HQC_DONE;
						end
					end
				end
				HQC_DONE: state_reg <= HQC_IDLE;
			endcase
		end
	end

	assign buf_push = state_reg == HQC_SCAN && scan_tx && scan_en &&
		wp[scan_reg] != rp[scan_reg] && buf_cnt_reg != 2'h2;
	assign buf_pop = line_tx_valid_reg && line_tx_ready;

	// Two-entry output buffer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			buf_data_reg[0]   <= 8'h00;
			buf_data_reg[1]   <= 8'h00;
			buf_cnt_reg       <= 2'h0;
			buf_rd_reg        <= 1'b0;
			buf_wr_reg        <= 1'b0;
			line_tx_byte_reg  <= 8'h00;
			line_tx_valid_reg <= 1'b0;
			last_tx_reg       <= 8'h00;
		end else if (clk_en) begin
			if (buf_push) begin
				buf_data_reg[buf_wr_reg] <= tx_byte_next;
				buf_wr_reg <= !buf_wr_reg;
			end
			if (buf_pop) begin
				buf_rd_reg <= !buf_rd_reg;
				last_tx_reg <= line_tx_byte_reg;
			end
			buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} -
				{1'b0, buf_pop};
			if (!line_tx_valid_reg || buf_pop) begin
				if (buf_cnt_reg > (buf_pop ? 2'h1 : 2'h0)) begin
					line_tx_byte_reg  <= buf_data_reg[buf_rd_reg ^ buf_pop];
					line_tx_valid_reg <= 1'b1;
				end else if (buf_push && buf_cnt_reg ==
					(buf_pop ? 2'h1 : 2'h0)) begin
					line_tx_byte_reg  <= tx_byte_next;
					line_tx_valid_reg <= 1'b1;
				end else begin
					line_tx_valid_reg <= 1'b0;
				end
			end
		end
	end

	// Register read mux
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			host_rdata_reg <= 8'h00;
		end else if (clk_en && host_rd) begin
			unique case (host_addr)
				hqc_pkg::OFF_WP_LO:    host_rdata_reg <= wp[q][7:0];
				hqc_pkg::OFF_WP_HI:    host_rdata_reg <= wp[q][15:8];
				hqc_pkg::OFF_RP_LO:    host_rdata_reg <= rp[q][7:0];
				hqc_pkg::OFF_RP_HI:    host_rdata_reg <= rp[q][15:8];
				hqc_pkg::OFF_FIN:      host_rdata_reg <= {3'h0, fin[q]};
				hqc_pkg::OFF_FOUT:     host_rdata_reg <= {3'h0, fout[q]};
				hqc_pkg::OFF_DATA,
				hqc_pkg::OFF_DATA_H:   host_rdata_reg <= qsel_reg[hqc_pkg::BIT_REV] ?
					rdata_rev : rd_byte;
				hqc_pkg::OFF_INT_DATA: host_rdata_reg <= last_tx_reg;
				hqc_pkg::OFF_STATUS:   host_rdata_reg <= {7'h00, busy_reg};
				default:               host_rdata_reg <= 8'h00;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### test/hqc_line_sink.sv
// Line-side sink model: slow ready, captures sent bytes.
// Assumes valid/ready transfers on the rising edge of clk.
`timescale 1ns/1ns
`default_nettype none
module hqc_line_sink (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Transmit stream
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_byte,
	output var  logic       tx_ready,
	// Capture results
	output var  logic [7:0] last_byte,
	output var  int         byte_count
);
	logic [1:0] stall;
	// Ready one cycle in four, moved at the falling edge
	always_ff @(negedge clk or negedge reset_n) begin
		if (!reset_n)
			stall <= 2'h0;
		else
			stall <= stall + 2'h1;
	end
	assign tx_ready = (stall == 2'h3);
	// Take a byte on each accepted transfer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			last_byte <= 8'h00;
			byte_count <= 0;
		end else if (tx_valid && tx_ready) begin
			last_byte <= tx_byte;
			byte_count <= byte_count + 1;
		end
	end
endmodule
`default_nettype wire

// ### test/hqc_queue_assertions.sv
// Port-level checks for the queue manager.
// Assumes a bind onto hqc_queue and one clock domain.
`timescale 1ns/1ns
`default_nettype none
module hqc_queue_assertions (
	// Clock and reset
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       clk_en,
	// Host port
	input wire logic       host_wr,
	input wire logic       host_rd,
	input wire logic [7:0] host_addr,
	input wire logic [7:0] host_rdata_reg,
	input wire logic       busy_reg,
	// Line side
	input wire logic [7:0] line_tx_byte_reg,
	input wire logic       line_tx_valid_reg,
	input wire logic       line_tx_ready
);
	logic [5:0] busy_cnt;
	logic       conn_seen;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Length of the current busy stretch
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			busy_cnt <= 6'h00;
		else if (!busy_reg)
			busy_cnt <= 6'h00;
		else if (clk_en)
			busy_cnt <= busy_cnt + 6'h01;
	end
	// Any connection write seen since reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			conn_seen <= 1'b0;
		else if (host_wr && host_addr == hqc_pkg::OFF_CONN)
			conn_seen <= 1'b1;
	end
	a_busy_rise: assert property (host_wr && clk_en && !busy_reg &&
		(host_addr == hqc_pkg::OFF_QSEL || host_addr == hqc_pkg::OFF_INC_RES)
		|=> busy_reg) else $error("busy did not rise");
	a_busy_bound: assert property (busy_cnt <= 6'h19)
		else $error("busy too long");
	a_busy_status: assert property (host_rd && clk_en &&
		host_addr == hqc_pkg::OFF_STATUS |=> host_rdata_reg[0] == $past(busy_reg))
		else $error("status busy wrong");
	a_tx_hold: assert property (line_tx_valid_reg && !line_tx_ready
		|=> line_tx_valid_reg && $stable(line_tx_byte_reg))
		else $error("tx byte dropped");
	a_fin_width: assert property (host_rd && clk_en &&
		host_addr == hqc_pkg::OFF_FIN |=> host_rdata_reg[7:5] == 3'h0)
		else $error("frame in too wide");
	a_fout_width: assert property (host_rd && clk_en &&
		host_addr == hqc_pkg::OFF_FOUT |=> host_rdata_reg[7:5] == 3'h0)
		else $error("frame out too wide");
	a_wp_span: assert property (host_rd && clk_en &&
		host_addr == hqc_pkg::OFF_WP_HI |=> host_rdata_reg[7:5] == 3'h0)
		else $error("pointer too wide");
	a_idle_line: assert property (!conn_seen |-> !line_tx_valid_reg)
		else $error("disabled queue sent");
endmodule
`default_nettype wire

// ### test/hqc_queue_tb_top.sv
// Bench for the queue manager: host register tests, line sink.
// Assumes the sink model and checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
module hqc_queue_tb_top;
	logic       clk;
	logic       reset_n;
	logic       host_wr;
	logic       host_rd;
	logic [7:0] host_addr;
	logic [7:0] host_wdata;
	logic [7:0] host_rdata_reg;
	logic       busy_reg;
	logic       sync;
	logic       en;
	logic [7:0] rx_byte;
	logic [7:0] tx_byte;
	logic       tx_valid;
	logic       tx_ready;
	logic [7:0] last_byte;
	int         byte_count;
	int         bad_count;
	int         cmp_count;
	int         i;
	hqc_queue DUT (.clk(clk), .reset_n(reset_n), .clk_en(en),
		.host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_rdata_reg(host_rdata_reg),
		.busy_reg(busy_reg), .frame_sync_pulse(sync),
		.line_rx_byte(rx_byte), .line_tx_byte_reg(tx_byte),
		.line_tx_valid_reg(tx_valid), .line_tx_ready(tx_ready));
	hqc_line_sink SINK (.clk(clk), .reset_n(reset_n), .tx_valid(tx_valid),
		.tx_byte(tx_byte), .tx_ready(tx_ready), .last_byte(last_byte),
		.byte_count(byte_count));
	always #10 clk = ~clk;
	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic hang(input string n);
		bad_count++;
		$display("[ERR] %s expected done seen timeout", n);
		conclude;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		host_addr = a;
		host_wdata = v;
		host_wr = 1'b1;
		@(negedge clk);
		host_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
		@(negedge clk);
		host_addr = a;
		host_rd = 1'b1;
		@(negedge clk);
		host_rd = 1'b0;
		chk(n, host_rdata_reg, e);
	endtask
	task automatic idle;
		for (i = 0; i < 26 && busy_reg !== 1'b0; i++)
			@(negedge clk);
		if (busy_reg !== 1'b0)
			hang("busy");
	endtask
	initial begin
		clk = 1'b0;
		reset_n = 1'b0;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = 8'h00;
		host_wdata = 8'h00;
		sync = 1'b0;
		en = 1'b1;
		rx_byte = 8'h00;
		bad_count = 0;
		cmp_count = 0;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		wr(hqc_pkg::OFF_QSEL, 8'h00);
		rd(hqc_pkg::OFF_STATUS, 8'h01, "status");
		idle;
		rd(hqc_pkg::OFF_WP_LO, 8'hff, "wp_lo");
		rd(hqc_pkg::OFF_WP_HI, 8'h01, "wp_hi");
		rd(hqc_pkg::OFF_RP_LO, 8'hff, "rp_lo");
		rd(hqc_pkg::OFF_FIN, 8'h0f, "fin");
		rd(hqc_pkg::OFF_FOUT, 8'h0f, "fout");
		$display("test reset values done");
		wr(hqc_pkg::OFF_QSEL, 8'h00);
		wr(hqc_pkg::OFF_DATA, 8'h11);
		idle;
		rd(hqc_pkg::OFF_WP_LO, 8'hff, "wp_busy");
		wr(hqc_pkg::OFF_CONN, 8'h02);
		wr(hqc_pkg::OFF_SUBCH, 8'h80);
		wr(hqc_pkg::OFF_DATA, 8'ha5);
		rd(hqc_pkg::OFF_WP_LO, 8'h80, "wp_wrap");
		rd(hqc_pkg::OFF_WP_HI, 8'h00, "wp_hi_wrap");
		rd(hqc_pkg::OFF_RP_LO, 8'hff, "rp_hold");
		$display("test busy and wrap done");
		sync = 1'b1;
		repeat (4) @(negedge clk);
		sync = 1'b0;
		for (i = 0; i < 400 && byte_count == 0; i++)
			@(negedge clk);
		if (byte_count == 0)
			hang("tx byte");
		repeat (200) @(negedge clk);
		chk("tx_byte", last_byte, 8'h5a);
		chk("tx_count", byte_count[7:0], 8'h01);
		wr(hqc_pkg::OFF_QSEL, 8'h00);
		idle;
		rd(hqc_pkg::OFF_RP_LO, 8'h80, "rp_step");
		$display("test line output done");
		wr(hqc_pkg::OFF_CONN, 8'h00);
		wr(hqc_pkg::OFF_INC_RES, 8'h01);
		idle;
		rd(hqc_pkg::OFF_FIN, 8'h00, "fin_wrap");
		wr(hqc_pkg::OFF_INC_RES, 8'h02);
		idle;
		rd(hqc_pkg::OFF_WP_LO, 8'hff, "wp_qreset");
		rd(hqc_pkg::OFF_FIN, 8'h0f, "fin_qreset");
		$display("test frame counter done");
		wr(hqc_pkg::OFF_CTRL, 8'h01);
		wr(hqc_pkg::OFF_CTRL, 8'h09);
		wr(hqc_pkg::OFF_CTRL, 8'h01);
		idle;
		wr(hqc_pkg::OFF_QSEL, 8'h00);
		idle;
		rd(hqc_pkg::OFF_FIN, 8'h1f, "fin_large");
		rd(hqc_pkg::OFF_WP_HI, 8'h07, "wp_large");
		rd(8'h30, 8'h00, "unmapped");
		$display("test memory size done");
		rx_byte = 8'h1e;
		wr(hqc_pkg::OFF_QSEL, 8'h81);
		idle;
		wr(hqc_pkg::OFF_CONN, 8'h02);
		wr(hqc_pkg::OFF_SUBCH, 8'h02);
		sync = 1'b1;
		repeat (4) @(negedge clk);
		sync = 1'b0;
		repeat (150) @(negedge clk);
		rd(hqc_pkg::OFF_WP_LO, 8'hc0, "rx_wp");
		rd(hqc_pkg::OFF_DATA, 8'h78, "rx_data");
		$display("test receive done");
		en = 1'b0;
		wr(hqc_pkg::OFF_QSEL, 8'h00);
		en = 1'b1;
		rd(hqc_pkg::OFF_STATUS, 8'h00, "frozen");
		$display("test clock enable done");
		conclude;
	end
endmodule
bind hqc_queue hqc_queue_assertions CHK (.clk(clk), .reset_n(reset_n),
	.clk_en(clk_en), .host_wr(host_wr), .host_rd(host_rd),
	.host_addr(host_addr), .host_rdata_reg(host_rdata_reg),
	.busy_reg(busy_reg), .line_tx_byte_reg(line_tx_byte_reg),
	.line_tx_valid_reg(line_tx_valid_reg), .line_tx_ready(line_tx_ready));
`default_nettype wire
